// ### hw/sram_host_pkg.sv
package sram_host_pkg;

	// ---------------------------------------------------------------
	// pin and timer widths and clock
	// ---------------------------------------------------------------
	localparam int ADDR_W  = 21;
	localparam int DATA_W  = 8;
	localparam int TIMER_W = 4;
	// clock period and all times in tenths of a nanosecond
	localparam int CLK_PERIOD_DNS = 200;

	// ---------------------------------------------------------------
	// timing figures, fast grade then slow grade; a single figure where both grades share it
	// ---------------------------------------------------------------
	localparam int READ_CYCLE_MIN_FAST_DNS           = 450;
	localparam int READ_CYCLE_MIN_SLOW_DNS           = 550;
	localparam int ADDRESS_ACCESS_MAX_FAST_DNS       = 450;
	localparam int ADDRESS_ACCESS_MAX_SLOW_DNS       = 550;
	localparam int SELECT_ACCESS_MAX_FAST_DNS        = 450;
	localparam int SELECT_ACCESS_MAX_SLOW_DNS        = 550;
	localparam int OUTPUT_ENABLE_ACCESS_MAX_FAST_DNS = 220;
	localparam int OUTPUT_ENABLE_ACCESS_MAX_SLOW_DNS = 250;
	localparam int OUTPUT_ENABLE_TURN_OFF_DNS        = 180;
	localparam int SELECT_TURN_OFF_DNS               = 180;
	localparam int WRITE_CYCLE_MIN_FAST_DNS          = 450;
	localparam int WRITE_CYCLE_MIN_SLOW_DNS          = 550;
	localparam int SELECT_TO_WRITE_END_FAST_DNS      = 350;
	localparam int SELECT_TO_WRITE_END_SLOW_DNS      = 400;
	localparam int ADDRESS_SETUP_WRITE_END_FAST_DNS  = 350;
	localparam int ADDRESS_SETUP_WRITE_END_SLOW_DNS  = 400;
	localparam int WRITE_STROBE_WIDTH_FAST_DNS       = 350;
	localparam int WRITE_STROBE_WIDTH_SLOW_DNS       = 400;
	localparam int DATA_SETUP_WRITE_END_DNS          = 250;
	localparam int WRITE_STROBE_TURN_OFF_FAST_DNS    = 180;
	localparam int WRITE_STROBE_TURN_OFF_SLOW_DNS    = 200;
	localparam int RETENTION_RECOVERY_FAST_DNS       = 450;
	localparam int RETENTION_RECOVERY_SLOW_DNS       = 550;

	// ---------------------------------------------------------------
	// conversions
	// ---------------------------------------------------------------
	// least time to whole cycles, rounded up, never below one
	function automatic int cyc_min(input int dns);
		int c;
		c = (dns + CLK_PERIOD_DNS - 1) / CLK_PERIOD_DNS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int max_of(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} request_t;

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic              corrected;
	} response_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              select_low_active_n;
		logic              select_high_active;
		logic              write_strobe_n;
		logic              output_enable_n;
		logic [DATA_W-1:0] data_out;
		logic              data_oe;
	} pins_t;

	localparam pins_t PINS_IDLE = '{
		addr:                '0,
		select_low_active_n: 1'b1,
		select_high_active:  1'b0,
		write_strobe_n:      1'b1,
		output_enable_n:     1'b1,
		data_out:            '0,
		data_oe:             1'b0
	};

endpackage

// ### hw/delay_timer.sv
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------
// down counter: expired is high once load_value cycles have run
// ---------------------------------------------------------------
module delay_timer #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic [W-1:0] load_value,
	output logic              expired
);

	logic [W-1:0] cnt_q;

	// loading n-1 gives exactly n cycles in the waiting state
	always_ff @(posedge clk)
	begin
		if (rst)
			cnt_q <= '0;
		else if (load)
			cnt_q <= load_value;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end

	assign expired = (cnt_q == '0);

endmodule

`default_nettype wire

// ### hw/sram_host.sv
// Contract
// RULE1: write happens only while strobe and both selects active
// RULE2: data timed against edge ending write overlap
// RULE3: read cycles spaced at least read cycle time
// RULE4: data and flag valid within address access time
// RULE5: old data held briefly after address change
// RULE6: data valid within select access time
// RULE7: data valid within output enable access time
// RULE8: outputs turn on after output enable falls
// RULE9: outputs float soon after output enable rises
// RULE10: select turn-on late, deselect turn-off early
// RULE11: turn-off always shorter than turn-on
// RULE12: power-up at select, power-down after deselect
// RULE13: write cycle lasts at least write cycle time
// RULE14: selects active long enough before write end
// RULE15: address stable long enough before write end
// RULE16: address stable from write start to end
// RULE17: write strobe low at least its minimum width
// RULE18: write data valid long enough before end
// RULE19: device floats outputs while write strobe low
// RULE20: strobe covers turn-off plus setup with enable low
// RULE21: wait recovery time after retention deselect
// RULE22: error flag tells whether read was corrected
// RULE23: device floats data when not reading
// RULE24: read selects, enables output, keeps strobe high
// RULE25: corrected data never written back by device
// RULE26: host drivers off while device may drive
`timescale 1ns/1ns
`default_nettype none

module sram_host #(
	parameter bit SLOW_GRADE = 1'b0
) (
	input  wire logic                            clk,
	input  wire logic                            rst,
	// user side
	input  wire logic                            req_valid,
	input  wire sram_host_pkg::request_t         req,
	output logic                                 req_ready,
	output logic                                 rsp_valid,
	output sram_host_pkg::response_t             rsp,
	input  wire logic                            retention_req,
	output logic                                 retention_ack,
	// memory pins
	output sram_host_pkg::pins_t                 pins,
	input  wire logic [sram_host_pkg::DATA_W-1:0] data_in,
	input  wire logic                            error_flag_in
);

	// ---------------------------------------------------------------
	// cycle counts for the chosen grade
	// ---------------------------------------------------------------
	localparam int READ_ACCESS = sram_host_pkg::max_of(
		sram_host_pkg::max_of(
			sram_host_pkg::cyc_min(SLOW_GRADE ?
				sram_host_pkg::ADDRESS_ACCESS_MAX_SLOW_DNS :
				sram_host_pkg::ADDRESS_ACCESS_MAX_FAST_DNS),
			sram_host_pkg::cyc_min(SLOW_GRADE ?
				sram_host_pkg::SELECT_ACCESS_MAX_SLOW_DNS :
				sram_host_pkg::SELECT_ACCESS_MAX_FAST_DNS)),
		sram_host_pkg::max_of(
			sram_host_pkg::cyc_min(SLOW_GRADE ?
				sram_host_pkg::OUTPUT_ENABLE_ACCESS_MAX_SLOW_DNS :
				sram_host_pkg::OUTPUT_ENABLE_ACCESS_MAX_FAST_DNS),
			sram_host_pkg::cyc_min(SLOW_GRADE ?
				sram_host_pkg::READ_CYCLE_MIN_SLOW_DNS :
				sram_host_pkg::READ_CYCLE_MIN_FAST_DNS)));
	localparam int TURNAROUND = sram_host_pkg::cyc_min(sram_host_pkg::max_of(
		sram_host_pkg::OUTPUT_ENABLE_TURN_OFF_DNS,
		sram_host_pkg::SELECT_TURN_OFF_DNS));
	localparam int DATA_SETUP =
		sram_host_pkg::cyc_min(sram_host_pkg::DATA_SETUP_WRITE_END_DNS);
	localparam int STROBE_OE_LOW = sram_host_pkg::cyc_min((SLOW_GRADE ?
		sram_host_pkg::WRITE_STROBE_TURN_OFF_SLOW_DNS :
		sram_host_pkg::WRITE_STROBE_TURN_OFF_FAST_DNS) +
		sram_host_pkg::DATA_SETUP_WRITE_END_DNS);
	localparam int WRITE_PULSE = sram_host_pkg::max_of(
		sram_host_pkg::max_of(
			sram_host_pkg::cyc_min(SLOW_GRADE ?
				sram_host_pkg::WRITE_STROBE_WIDTH_SLOW_DNS :
				sram_host_pkg::WRITE_STROBE_WIDTH_FAST_DNS),
			sram_host_pkg::cyc_min(SLOW_GRADE ?
				sram_host_pkg::SELECT_TO_WRITE_END_SLOW_DNS :
				sram_host_pkg::SELECT_TO_WRITE_END_FAST_DNS)),
		sram_host_pkg::max_of(DATA_SETUP,
			sram_host_pkg::cyc_min(SLOW_GRADE ?
				sram_host_pkg::ADDRESS_SETUP_WRITE_END_SLOW_DNS :
				sram_host_pkg::ADDRESS_SETUP_WRITE_END_FAST_DNS)));
	localparam int WRITE_CYCLE = sram_host_pkg::cyc_min(SLOW_GRADE ?
		sram_host_pkg::WRITE_CYCLE_MIN_SLOW_DNS :
		sram_host_pkg::WRITE_CYCLE_MIN_FAST_DNS);
	localparam int WRITE_TAIL = sram_host_pkg::max_of(1,
		WRITE_CYCLE - WRITE_PULSE);
	localparam int RECOVERY = sram_host_pkg::cyc_min(SLOW_GRADE ?
		sram_host_pkg::RETENTION_RECOVERY_SLOW_DNS :
		sram_host_pkg::RETENTION_RECOVERY_FAST_DNS);
	localparam int ACCESS_GAP = sram_host_pkg::max_of(WRITE_CYCLE,
		sram_host_pkg::cyc_min(SLOW_GRADE ?
			sram_host_pkg::READ_CYCLE_MIN_SLOW_DNS :
			sram_host_pkg::READ_CYCLE_MIN_FAST_DNS));
	localparam int TW = sram_host_pkg::TIMER_W;
	// the response flop lands one cycle after the data is sampled
	localparam int RSP_LAT = READ_ACCESS + 1;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE    = 6'h01,
		ST_READ    = 6'h02,
		ST_TURN    = 6'h04,
		ST_STROBE  = 6'h08,
		ST_TAIL    = 6'h10,
		ST_RETAIN  = 6'h20
	} state_t;

	typedef enum logic [1:0] {
		PH_NONE    = 2'h0,
		PH_RECOVER = 2'h1
	} phase_t;

	state_t            state_q;
	phase_t            phase_q;
	logic              timer_load;
	logic [TW-1:0]     timer_value;
	logic              timer_done;
	logic              accept;
	logic              overlap;
	logic              selected;
	logic [TW-1:0]     overlap_len_q;
	logic [TW-1:0]     gap_q;
	logic [TW-1:0]     since_retain_q;

	// count n cycles as a load of n-1
	function automatic logic [TW-1:0] wait_of(input int n);
		return TW'(n - 1);
	endfunction

	// ---------------------------------------------------------------
	// timer and decode
	// ---------------------------------------------------------------
	delay_timer #(
		.W (TW)
	) u_timer (
		.clk        (clk),
		.rst        (rst),
		.load       (timer_load),
		.load_value (timer_value),
		.expired    (timer_done)
	);

	// retention takes priority over a waiting access
	assign accept   = (state_q == ST_IDLE) && req_ready && req_valid &&
		!retention_req;
	assign selected = !pins.select_low_active_n && pins.select_high_active;
	assign overlap  = selected && !pins.write_strobe_n; // RULE1

	// timer reload at each timed entry
	always_comb
	begin
		timer_load  = 1'b0;
		timer_value = '0;
		case (state_q)
			ST_IDLE:
			begin
				timer_load  = accept;
				timer_value = req.write ? wait_of(WRITE_PULSE) :
					wait_of(READ_ACCESS); // RULE4 RULE6 RULE7
			end
			ST_READ:
			begin
				timer_load  = timer_done;
				timer_value = wait_of(TURNAROUND); // RULE9 RULE10 RULE11
			end
			ST_STROBE:
			begin
				timer_load  = timer_done;
				timer_value = wait_of(WRITE_TAIL); // RULE13
			end
			ST_RETAIN:
			begin
				// load once only: reloading every cycle would never expire
				timer_load  = !retention_req && phase_q == PH_NONE;
				timer_value = wait_of(RECOVERY); // RULE21
			end
			default:
			begin
				timer_load  = 1'b0;
				timer_value = '0;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	// state and pin drive move together so pins come from flops
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			pins    <= sram_host_pkg::PINS_IDLE;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (retention_req)
					begin
						// deselect at once; no setup needed before retention
						state_q <= ST_RETAIN; // RULE21
						pins    <= sram_host_pkg::PINS_IDLE;
					end
					else if (accept && req.write)
					begin
						// address, selects, strobe and data on one edge
						state_q                    <= ST_STROBE;
						pins.addr                  <= req.addr; // RULE16
						pins.select_low_active_n   <= 1'b0;
						pins.select_high_active    <= 1'b1;
						pins.write_strobe_n        <= 1'b0; // RULE1
						pins.output_enable_n       <= 1'b1; // RULE20
						pins.data_out              <= req.wdata; // RULE18
						pins.data_oe               <= 1'b1;
					end
					else if (accept)
					begin
						state_q                    <= ST_READ;
						pins.addr                  <= req.addr;
						pins.select_low_active_n   <= 1'b0;
						pins.select_high_active    <= 1'b1;
						pins.write_strobe_n        <= 1'b1; // RULE24
						pins.output_enable_n       <= 1'b0;
						pins.data_oe               <= 1'b0; // RULE26
					end
				end
				ST_READ:
				begin
					if (timer_done)
					begin
						state_q                  <= ST_TURN;
						pins.output_enable_n     <= 1'b1;
						pins.select_low_active_n <= 1'b1;
						pins.select_high_active  <= 1'b0;
					end
				end
				// device still releasing the bus: no host drive yet
				ST_TURN:
				begin
					if (timer_done)
						state_q <= ST_IDLE; // RULE26
				end
				ST_STROBE:
				begin
					if (timer_done)
					begin
						// strobe ends the write; data held one more cycle
						state_q             <= ST_TAIL;
						pins.write_strobe_n <= 1'b1; // RULE2 RULE17
					end
				end
				ST_TAIL:
				begin
					if (timer_done)
					begin
						state_q                  <= ST_IDLE;
						pins.select_low_active_n <= 1'b1;
						pins.select_high_active  <= 1'b0;
						pins.data_oe             <= 1'b0;
					end
				end
				ST_RETAIN:
				begin
					if (phase_q == PH_RECOVER && timer_done)
						state_q <= ST_IDLE; // RULE21
				end
				default:
				begin
					state_q <= ST_IDLE;
					pins    <= sram_host_pkg::PINS_IDLE;
				end
			endcase
		end
	end

	// recovery phase inside the retention state
	always_ff @(posedge clk)
	begin
		if (rst)
			phase_q <= PH_NONE;
		else if (state_q != ST_RETAIN)
			phase_q <= PH_NONE;
		else if (!retention_req)
			phase_q <= PH_RECOVER;
		else
			phase_q <= PH_NONE;
	end

	// ---------------------------------------------------------------
	// user handshake
	// ---------------------------------------------------------------
	// ready only after a whole idle cycle so spacing is always kept
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			req_ready     <= 1'b0;
			retention_ack <= 1'b0;
		end
		else
		begin
			req_ready     <= (state_q == ST_IDLE) && !accept &&
				!retention_req;
			retention_ack <= (state_q == ST_RETAIN);
		end
	end

	// corrected flag is captured with the data, never written back
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rsp_valid <= 1'b0;
			rsp       <= '0;
		end
		else
		begin
			rsp_valid <= 1'b0;
			if (state_q == ST_READ && timer_done)
			begin
				rsp_valid     <= 1'b1;
				rsp.rdata     <= data_in; // RULE4
				rsp.corrected <= error_flag_in; // RULE22 RULE25
			end
			else if (state_q == ST_TAIL && timer_done)
				rsp_valid <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// helper counters for checks
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			overlap_len_q  <= '0;
			gap_q          <= '1;
			since_retain_q <= '1;
		end
		else
		begin
			overlap_len_q <= overlap ? overlap_len_q + 1'b1 : '0;
			if (accept)
				gap_q <= TW'(1);
			else if (gap_q != '1)
				gap_q <= gap_q + 1'b1;
			// recovery is counted from the end of retention, not of the state
			if (state_q == ST_RETAIN && phase_q == PH_NONE)
				since_retain_q <= '0;
			else if (since_retain_q != '1)
				since_retain_q <= since_retain_q + 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_strobe_width: assert property (@(posedge clk) disable iff (rst) // RULE17
		$fell(overlap) |-> overlap_len_q >= TW'(WRITE_PULSE))
		else $error("write overlap shorter than strobe width");

	a_write_end_setup: assert property (@(posedge clk) disable iff (rst) // RULE18
		$fell(overlap) |-> overlap_len_q >= TW'(DATA_SETUP)
			&& $past(pins.data_oe) && pins.data_oe)
		else $error("data not set up or held at write end");

	a_overlap_stable: assert property (@(posedge clk) disable iff (rst) // RULE16
		overlap && $past(overlap) |-> $stable(pins.addr) &&
			$stable(pins.data_out) && pins.data_oe)
		else $error("address or data moved during write");

	a_access_spacing: assert property (@(posedge clk) disable iff (rst) // RULE3
		accept |-> gap_q >= TW'(ACCESS_GAP))
		else $error("accesses closer than cycle time");

	a_read_bus_off: assert property (@(posedge clk) disable iff (rst) // RULE26
		!pins.output_enable_n |-> !pins.data_oe && pins.write_strobe_n
			&& selected)
		else $error("host drives or strobes during read");

	a_turnaround: assert property (@(posedge clk) disable iff (rst) // RULE26
		$rose(pins.output_enable_n) |-> !pins.data_oe[*2])
		else $error("host drove data before device released bus");

	a_oe_high_write: assert property (@(posedge clk) disable iff (rst) // RULE20
		overlap |-> pins.output_enable_n ||
			overlap_len_q >= TW'(STROBE_OE_LOW))
		else $error("strobe too short with output enable low");

	a_recovery: assert property (@(posedge clk) disable iff (rst) // RULE21
		selected |-> since_retain_q >= TW'(RECOVERY))
		else $error("access before retention recovery");

	a_read_response: assert property (@(posedge clk) disable iff (rst) // RULE4
		accept && !req.write |-> ##(RSP_LAT) rsp_valid)
		else $error("read data not returned after access time");

endmodule

`default_nettype wire

// ### testbench/sram_dev_model.sv
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------
// memory device seen from its pins, fast grade, times in ns
// ---------------------------------------------------------------
module sram_dev_model #(
	parameter int ACC    = 45,
	parameter int OE_ACC = 22
) (
	input  wire sram_host_pkg::pins_t              p,
	input  wire logic                              bad_en,
	input  wire logic [sram_host_pkg::ADDR_W-1:0] bad_addr,
	input  wire logic                              retention,
	output logic [sram_host_pkg::DATA_W-1:0]      dq,
	output logic                                   flag,
	output int                                     viol
);
	logic [sram_host_pkg::DATA_W-1:0] mem [int];
	logic                             drive = 1'b0;
	time                              ta, ts, to, tw, td, tr, tws, tss, tre;
	wire logic sel = !p.select_low_active_n && p.select_high_active;
	wire logic wr  = sel && !p.write_strobe_n;
	wire logic rd  = sel && p.write_strobe_n && !p.output_enable_n;
	wire logic pwr = sel;

	// quiet start, no violations seen yet
	initial
	begin
		dq = '0;
		flag = 1'b0;
		viol = 0;
	end

	// time of the last edge on each pin group
	always @(p.addr) ta = $time;
	always @(sel) ts = $time;
	always @(p.output_enable_n) to = $time;
	always @(p.write_strobe_n) tw = $time;
	always @(p.data_out, p.data_oe) td = $time;
	always @(negedge retention) tre = $time;
	always @(posedge wr) tws = $time;

	// accesses spaced apart; recovery after a retention spell
	always @(posedge sel)
	begin
		if ($time - tss < ACC || $time - tre < ACC)
			viol++;
		tss = $time;
	end

	// data taken at the edge that ends the overlap; host timing judged
	always @(negedge wr)
	begin
		if (p.data_oe)
			mem[int'(p.addr)] = p.data_out;
		if ($time - tws < 35 || $time - ts < 35 || ta > tws)
			viol++;
		if ($time - ta < 35 || $time - td < 25 || !p.data_oe)
			viol++;
		if (!p.output_enable_n && $time - tws < 43)
			viol++;
	end

	// read path; a floating or unsettled line shows a toggling pattern
	// so a sample taken too early never matches by luck
	always #1
	begin
		if (rd)
			tr = $time;
		drive <= rd ? ($time - to >= 5 && $time - ts >= 10 && $time - tw >= 10)
			: (drive && $time - tr < 17);
		if (rd && $time - ta >= ACC && $time - ts >= ACC && $time - to >= OE_ACC)
		begin
			dq <= mem.exists(int'(p.addr)) ? mem[int'(p.addr)] : 8'h00;
			flag <= bad_en && p.addr == bad_addr;
		end
		else if (!(drive && $time - ta < 10))
		begin
			dq <= ~dq;
			flag <= ~flag;
		end
		if (drive && p.data_oe)
			viol++;
	end
endmodule
`default_nettype wire

// ### testbench/test_sram_host.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) \
	begin \
		n_tests++; \
		if ((g) !== (e)) \
		begin \
			error_cnt++; \
			$display("BAD %s exp %0h got %0h", nm, e, g); \
		end \
	end

module test_sram_host;
	logic                             clk, rst, req_valid, req_ready;
	logic                             rsp_valid, retention_req;
	logic                             retention_ack, error_flag_in, bad_en;
	sram_host_pkg::request_t          req;
	sram_host_pkg::response_t         rsp;
	sram_host_pkg::pins_t             pins;
	logic [sram_host_pkg::DATA_W-1:0] data_in, dq;
	logic [sram_host_pkg::ADDR_W-1:0] bad_addr;
	int                               error_cnt, n_tests, viol;
	logic [sram_host_pkg::ADDR_W-1:0] adr [4] = '{21'h000000, 21'h1fffff,
		21'h0aaaaa, 21'h155555};
	logic [sram_host_pkg::DATA_W-1:0] dat [4] = '{8'h00, 8'hff, 8'ha5, 8'h5a};

	// data pins: the host's drive wins, else the device's pattern
	assign data_in = pins.data_oe ? pins.data_out : dq;

	sram_host sram_host_i (.clk(clk), .rst(rst), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp(rsp), .retention_req(retention_req),
		.retention_ack(retention_ack), .pins(pins), .data_in(data_in),
		.error_flag_in(error_flag_in));

	sram_dev_model sram_dev_model_i (.p(pins), .bad_en(bad_en),
		.bad_addr(bad_addr), .retention(retention_req), .dq(dq),
		.flag(error_flag_in), .viol(viol));

	// ---------------------------------------------------------------
	// clock, verdict and watchdog
	// ---------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic print_verdict;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// whole run is under two hundred cycles; this is ample margin
	initial
	begin
		#100000;
		error_cnt++;
		print_verdict;
	end

	// ---------------------------------------------------------------
	// bus cycles
	// ---------------------------------------------------------------
	task automatic wait_acc;
		int i;
		i = 0;
		do begin @(posedge clk); i++; end while (!req_ready && i < 20);
	endtask

	task automatic wait_rsp(output int k);
		k = 0;
		do begin @(posedge clk); k++; end while (!rsp_valid && k < 20);
	endtask

	task automatic xfer(
		input  logic                             w,
		input  logic [sram_host_pkg::ADDR_W-1:0] a,
		input  logic [sram_host_pkg::DATA_W-1:0] d,
		output int                               k
	);
		req_valid <= 1'b1;
		req <= '{write: w, addr: a, wdata: d};
		wait_acc;
		req_valid <= 1'b0;
		wait_rsp(k);
	endtask

	// read one byte and judge data, flag and latency
	task automatic rd_chk(
		input logic [sram_host_pkg::ADDR_W-1:0] a,
		input logic [sram_host_pkg::DATA_W-1:0] d,
		input logic                             c
	);
		int k;
		xfer(1'b0, a, '0, k);
		`CHK("read data", d, rsp.rdata)
		`CHK("error flag", c, rsp.corrected)
		`CHK("read latency", 4, k)
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		`CHK("pins in reset", sram_host_pkg::PINS_IDLE, pins)
		`CHK("ready in reset", 1'b0, req_ready)
	endtask

	// boundary addresses, an overwrite, then read back
	task automatic t_rw;
		int k;
		for (int i = 0; i < 4; i++)
		begin
			xfer(1'b1, adr[i], dat[i], k);
			`CHK("write latency", 4, k)
		end
		xfer(1'b1, adr[0], 8'h3c, k);
		dat[0] = 8'h3c;
		for (int i = 0; i < 4; i++)
			rd_chk(adr[i], dat[i], 1'b0);
	endtask

	// flagged location read twice: flag stays since nothing is rewritten
	task automatic t_ecc;
		bad_addr <= adr[2];
		bad_en <= 1'b1;
		rd_chk(adr[2], dat[2], 1'b1);
		rd_chk(adr[2], dat[2], 1'b1);
		rd_chk(adr[3], dat[3], 1'b0);
	endtask

	// request held valid while busy: swapped in only when taken
	task automatic t_busy;
		int k;
		req_valid <= 1'b1;
		req <= '{write: 1'b0, addr: adr[1], wdata: 8'h00};
		wait_acc;
		req <= '{write: 1'b0, addr: adr[3], wdata: 8'h00};
		wait_rsp(k);
		`CHK("first of pair", dat[1], rsp.rdata)
		wait_acc;
		req_valid <= 1'b0;
		wait_rsp(k);
		`CHK("second of pair", dat[3], rsp.rdata)
	endtask

	// retention blocks access; recovery precedes the next one
	task automatic t_ret;
		int   k;
		logic seen;
		seen = 1'b0;
		retention_req <= 1'b1;
		for (k = 0; k < 10 && !retention_ack; k++)
			@(posedge clk);
		`CHK("retention ack", 1'b1, retention_ack)
		req_valid <= 1'b1;
		req <= '{write: 1'b0, addr: adr[1], wdata: 8'h00};
		repeat (10)
		begin
			@(posedge clk);
			seen = seen | rsp_valid | pins.select_high_active;
		end
		`CHK("held off in retention", 1'b0, seen)
		retention_req <= 1'b0;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
			if (req_ready)
				req_valid <= 1'b0;
		end while (!rsp_valid && k < 30);
		`CHK("recovery wait", 10, k)
		`CHK("read after recovery", dat[1], rsp.rdata)
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		retention_req = 1'b0;
		bad_en = 1'b0;
		bad_addr = '0;
		repeat (4) @(posedge clk);
		t_reset;
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_rw;
		t_ecc;
		t_busy;
		t_ret;
		repeat (4) @(posedge clk);
		`CHK("host pin timing", 0, viol)
		print_verdict;
	end
endmodule
`default_nettype wire
